// ==== src/fpu_exception_response.v ====
// Exception detection and masked response of a floating-point coprocessor
//
// Behaviour
// RL1: Masked overflow or underflow results are rounded by the selected mode.
// RL2: Masked underflow flags only when denormalizing also loses accuracy.
// RL3: Sqrt, divide, remainder, decimal and integer stores normalize denormals.
// RL4: Sqrt, decimal store-pop and remainder may raise underflow.
// RL5: Transcendental and extract operations may raise denormal-operand.
// RL6: Other exceptions may take precedence over denormal-operand.
// RL7: Masked denormal: operands normalized, operation continues, no unnormal.
// RL8: Extract of zero raises zero-divide, second register gets minus infinity.
// RL9: Stack fault flag set when invalid comes from stack over or underflow.
// RL10: Extended-precision load never raises denormal-operand.
// RL11: Single or double load of denormal converts and raises denormal.
// RL12: Single or double load of signaling NaN raises invalid.
// RL13: Generated NaNs are always quiet; quiet and signaling are told apart.
// RL14: Signaling NaN operands raise invalid; quiet NaNs normally do not.
// RL15: Compare, integer store, decimal store-pop flag invalid on quiet NaN.
// RL16: Tangent stack overflow with overflow masked: both registers quiet NaN.
// RL17: Scale of zero by infinity raises invalid.
// RL18: Scale finite by minus or plus infinity gives signed zero or infinity.
// RL19: Unmasked massive overflow or underflow gives signed infinity or zero.
// RL20: Reset, initialize, incomplete remainder clear the four condition bits.
// RL21: Exception flags stay set until initialize or clear-exceptions.
`timescale 1ns/1ps
`default_nettype none
`include "fpu_exc_consts.vh"

module fpu_exception_response
(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output wire [31:0] prdata
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire        setup_phase;
  wire        access_phase;
  wire        wr_en;
  reg         hit;
  reg  [31:0] rd_val;
  reg  [31:0] prdata_q;

  // ************************************************************
  // Architectural state
  // ************************************************************
  reg  [`EXC_W-1:0] mask_q;
  reg  [1:0]        rc_q;
  reg  [`EXC_W-1:0] flags_q;
  reg  [`EXC_W-1:0] flags_d;
  reg               sf_q;
  reg               sf_d;
  reg  [3:0]        cc_q;
  reg  [3:0]        cc_d;
  reg  [31:0]       result_q;
  reg  [31:0]       result_d;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  // Zero wait states: every access phase completes at once
  assign pready       = 1'b1;
  assign pslverr      = access_phase & ~hit;
  assign prdata       = prdata_q;
  assign wr_en        = access_phase & pwrite & hit;

  always @*
  begin
    hit    = 1'b1;
    rd_val = `ZERO32;
    if (paddr == `ADDR_CTRL)
    begin
      rd_val[`EXC_W-1:0]                = mask_q;
      rd_val[`CTRL_RC_MSB:`CTRL_RC_LSB] = rc_q;
    end
    else if (paddr == `ADDR_STATUS)
    begin
      rd_val[`EXC_W-1:0]              = flags_q;
      rd_val[`ST_SF]                  = sf_q;
      rd_val[`ST_ES]                  = |(flags_q & ~mask_q);
      rd_val[`ST_CC_MSB:`ST_CC_LSB]   = cc_q;
    end
    else if (paddr == `ADDR_CMD)
      rd_val = `ZERO32;
    else if (paddr == `ADDR_RESULT)
      rd_val = result_q;
    else
      hit = 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= `ZERO32;
    else if (setup_phase && !pwrite)
      prdata_q <= rd_val;
  end

  // ************************************************************
  // Command fields
  // ************************************************************
  // Fields are only meaningful in the access cycle of a command write
  wire       cmd_go;
  wire [3:0] op;
  wire [2:0] a_cl;
  wire [2:0] b_cl;
  wire       a_sgn;
  wire       b_sgn;
  wire [1:0] fmt;
  wire       stk_ovf;
  wire       stk_unf;
  wire       tiny;
  wire       loss;
  wire       huge;
  wire       massive;
  wire       inexact;
  wire       incomp;

  assign cmd_go  = wr_en & (paddr == `ADDR_CMD);
  assign op      = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
  assign a_cl    = pwdata[`CMD_ACL_MSB:`CMD_ACL_LSB];
  assign b_cl    = pwdata[`CMD_BCL_MSB:`CMD_BCL_LSB];
  assign a_sgn   = pwdata[`CMD_ASGN];
  assign b_sgn   = pwdata[`CMD_BSGN];
  assign fmt     = pwdata[`CMD_FMT_MSB:`CMD_FMT_LSB];
  assign stk_ovf = pwdata[`CMD_STK_OVF];
  assign stk_unf = pwdata[`CMD_STK_UNF];
  assign tiny    = pwdata[`CMD_TINY];
  assign loss    = pwdata[`CMD_LOSS];
  assign huge    = pwdata[`CMD_HUGE];
  assign massive = pwdata[`CMD_MASSIVE];
  assign inexact = pwdata[`CMD_INEXACT];
  assign incomp  = pwdata[`CMD_INCOMP];

  // ************************************************************
  // Operation classes
  // ************************************************************
  wire two_op;
  wire numeric;
  wire unf_able;
  wire nan_strict;
  wire a_snan;
  wire b_snan;
  wire a_nan;
  wire b_nan;
  wire a_den;
  wire b_den;
  wire a_fin;

  assign two_op     = (op == `OP_DIV) | (op == `OP_PREM) |
                      (op == `OP_COMPARE) | (op == `OP_SCALE) |
                      (op == `OP_ARITH);
  assign numeric    = (op != `OP_NOP) & (op != `OP_INIT) &
                      (op != `OP_CLEAR_EXC);
  assign unf_able   = (op == `OP_SQRT) | (op == `OP_BCD_POP) |
                      (op == `OP_PREM) | (op == `OP_DIV) |
                      (op == `OP_SCALE) | (op == `OP_ARITH) |
                      (op == `OP_TRANSC); // RL4
  assign nan_strict = (op == `OP_COMPARE) | (op == `OP_STORE_INT) |
                      (op == `OP_BCD_POP);
  assign a_snan     = a_cl == `CL_SNAN;
  assign b_snan     = two_op & (b_cl == `CL_SNAN);
  assign a_nan      = a_snan | (a_cl == `CL_QNAN);
  assign b_nan      = two_op & (b_snan | (b_cl == `CL_QNAN));
  assign a_fin      = (a_cl == `CL_ZERO) | (a_cl == `CL_NORMAL) |
                      (a_cl == `CL_DENORM);
  // Extended load is a plain transfer, no denormal check
  assign a_den      = (a_cl == `CL_DENORM) &
                      ~((op == `OP_LOAD) & (fmt == `FMT_EXT)); // RL10 RL11 RL5
  assign b_den      = two_op & (b_cl == `CL_DENORM);

  // ************************************************************
  // Exception detection
  // ************************************************************
  reg       inv_r;
  reg       den_r;
  reg       zdiv_r;
  reg       ovf_r;
  reg       unf_r;
  reg       prc_r;
  reg       scale_inf;
  reg [3:0] top_res;
  reg [3:0] sec_res;
  reg       rounded;
  reg       normed;
  reg       res_sgn;

  // Invalid and zero-divide both outrank the value exceptions, but not each other;
  // denormal-operand gives way to invalid
  always @*
  begin
    inv_r     = 1'b0;
    den_r     = 1'b0;
    zdiv_r    = 1'b0;
    ovf_r     = 1'b0;
    unf_r     = 1'b0;
    prc_r     = 1'b0;
    scale_inf = (op == `OP_SCALE) & (b_cl == `CL_INF);
    top_res   = `RES_NONE;
    sec_res   = `RES_NONE;
    rounded   = 1'b0;
    normed    = 1'b0;
    res_sgn   = a_sgn ^ (two_op & b_sgn & (op == `OP_DIV));
    if (numeric)
    begin
      // Invalid sources
      if (stk_ovf || stk_unf)
        inv_r = 1'b1; // RL9
      if (a_snan || b_snan)
        inv_r = 1'b1; // RL12 RL14
      if (nan_strict && (a_nan || b_nan))
        inv_r = 1'b1; // RL15
      if (scale_inf && (a_cl == `CL_ZERO))
        inv_r = 1'b1; // RL17
      // Denormal only when invalid did not fire
      if ((a_den || b_den) && !inv_r)
        den_r = 1'b1; // RL6 RL5 RL11
      // Denormals are normalized when denormal is masked, never an invalid cause
      if ((a_den || b_den) && mask_q[`EXC_DEN])
        normed = 1'b1; // RL3 RL7
      // Zero divide
      if ((op == `OP_XTRACT) && (a_cl == `CL_ZERO))
      begin
        zdiv_r  = 1'b1; // RL8
        sec_res = `RES_NEG_INF; // RL8
      end
      if ((op == `OP_DIV) && (b_cl == `CL_ZERO) &&
          (a_cl != `CL_ZERO) && !a_nan && (a_cl != `CL_INF))
        zdiv_r = 1'b1;
      // Overflow and underflow only without invalid
      if (!inv_r && !zdiv_r)
      begin
        if (huge)
          ovf_r = 1'b1;
        if (tiny && unf_able)
          unf_r = mask_q[`EXC_UNF] ? loss : 1'b1; // RL2 RL4
        if (inexact || (tiny && loss))
          prc_r = 1'b1;
      end
      // Results
      if (inv_r)
      begin
        if (mask_q[`EXC_INV])
          top_res = `RES_QNAN; // RL13
      end
      else if (a_nan || b_nan)
        top_res = `RES_QNAN; // RL13
      else if (scale_inf && a_fin)
        top_res = (b_sgn ? (a_sgn ? `RES_NEG_ZERO : `RES_POS_ZERO)
                         : (a_sgn ? `RES_NEG_INF : `RES_POS_INF)); // RL18
      else if (huge && mask_q[`EXC_OVF])
      begin
        rounded = 1'b1; // RL1
        if (rc_q == `RC_NEAREST)
          top_res = res_sgn ? `RES_NEG_INF : `RES_POS_INF;
        else if (rc_q == `RC_CHOP)
          top_res = res_sgn ? `RES_NEG_MAX : `RES_POS_MAX;
        else if (rc_q == `RC_DOWN)
          top_res = res_sgn ? `RES_NEG_INF : `RES_POS_MAX;
        else
          top_res = res_sgn ? `RES_NEG_MAX : `RES_POS_INF;
      end
      else if (huge && massive)
        top_res = res_sgn ? `RES_NEG_INF : `RES_POS_INF; // RL19
      else if (tiny && mask_q[`EXC_UNF])
      begin
        rounded = 1'b1; // RL1
        top_res = `RES_DENORM;
      end
      else if (tiny && massive)
        top_res = res_sgn ? `RES_NEG_ZERO : `RES_POS_ZERO; // RL19
      // Tangent push overflow with overflow masked leaves two quiet NaNs
      if ((op == `OP_TANGENT) && stk_ovf && mask_q[`EXC_OVF])
      begin
        top_res = `RES_QNAN; // RL16
        sec_res = `RES_QNAN; // RL16
      end
    end
  end

  // ************************************************************
  // Status next state
  // ************************************************************
  wire [`EXC_W-1:0] new_exc;

  assign new_exc = {prc_r, unf_r, ovf_r, zdiv_r, den_r, inv_r};

  // Flags accumulate until initialize or clear-exceptions; clearing commands carry no new exceptions
  always @*
  begin
    flags_d  = flags_q;
    sf_d     = sf_q;
    cc_d     = cc_q;
    result_d = result_q;
    if (cmd_go)
    begin
      if ((op == `OP_INIT) || (op == `OP_CLEAR_EXC))
      begin
        flags_d = {`EXC_W{1'b0}}; // RL21
        sf_d    = 1'b0;
      end
      else
      begin
        flags_d = flags_q | new_exc; // RL21
        sf_d    = sf_q | (inv_r & (stk_ovf | stk_unf)); // RL9
      end
      if (op == `OP_INIT)
        cc_d = `CC_RST; // RL20
      else if ((op == `OP_PREM) && incomp)
        cc_d = `CC_RST; // RL20
      else if ((op == `OP_COMPARE) && (a_nan || b_nan))
        cc_d = `CC_UNORDERED;
      if (numeric)
      begin
        result_d                          = `ZERO32;
        result_d[`RS_TOP_MSB:`RS_TOP_LSB] = top_res;
        result_d[`RS_SEC_MSB:`RS_SEC_LSB] = sec_res;
        result_d[`RS_ROUNDED]             = rounded;
        result_d[`RS_RC_MSB:`RS_RC_LSB]   = rc_q;
        result_d[`RS_NORMED]              = normed;
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  wire ctrl_wr;
  wire init_go;

  // Initialize brings masks and rounding back to their reset values
  assign ctrl_wr = wr_en & (paddr == `ADDR_CTRL);
  assign init_go = cmd_go & (op == `OP_INIT);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q   <= `CTRL_MASK_RST;
      rc_q     <= `RC_NEAREST;
      flags_q  <= {`EXC_W{1'b0}};
      sf_q     <= 1'b0;
      cc_q     <= `CC_RST; // RL20
      result_q <= `ZERO32;
    end
    else
    begin
      flags_q  <= flags_d;
      sf_q     <= sf_d;
      cc_q     <= cc_d;
      result_q <= result_d;
      if (ctrl_wr)
      begin
        mask_q <= pwdata[`EXC_W-1:0];
        rc_q   <= pwdata[`CTRL_RC_MSB:`CTRL_RC_LSB];
      end
      else if (init_go)
      begin
        mask_q <= `CTRL_MASK_RST;
        rc_q   <= `RC_NEAREST;
      end
    end
  end

endmodule
`default_nettype wire

// ==== src/fpu_exc_consts.vh ====
// Constants for the floating-point exception response block
`ifndef FPU_EXC_CONSTS_VH
`define FPU_EXC_CONSTS_VH

// Register byte addresses
`define ADDR_CTRL     12'h000
`define ADDR_STATUS   12'h004
`define ADDR_CMD      12'h008
`define ADDR_RESULT   12'h00C

// Exception bit positions, shared by mask and flag fields
`define EXC_W         6
`define EXC_INV       0
`define EXC_DEN       1
`define EXC_ZDIV      2
`define EXC_OVF       3
`define EXC_UNF       4
`define EXC_PREC      5

// Control register fields
`define CTRL_RC_LSB   10
`define CTRL_RC_MSB   11
`define CTRL_MASK_RST 6'h3F
`define RC_NEAREST    2'h0
`define RC_DOWN       2'h1
`define RC_UP         2'h2
`define RC_CHOP       2'h3

// Status register fields
`define ST_SF         6
`define ST_ES         7
`define ST_CC_LSB     8
`define ST_CC_MSB     11
`define CC_RST        4'h0
`define CC_UNORDERED  4'hD

// Command register fields
`define CMD_OP_LSB    0
`define CMD_OP_MSB    3
`define CMD_ACL_LSB   4
`define CMD_ACL_MSB   6
`define CMD_ASGN      7
`define CMD_BCL_LSB   8
`define CMD_BCL_MSB   10
`define CMD_BSGN      11
`define CMD_FMT_LSB   12
`define CMD_FMT_MSB   13
`define CMD_STK_OVF   14
`define CMD_STK_UNF   15
`define CMD_TINY      16
`define CMD_LOSS      17
`define CMD_HUGE      18
`define CMD_MASSIVE   19
`define CMD_INEXACT   20
`define CMD_INCOMP    21

// Operation codes
`define OP_NOP        4'h0
`define OP_LOAD       4'h1
`define OP_SQRT       4'h2
`define OP_DIV        4'h3
`define OP_PREM       4'h4
`define OP_BCD_POP    4'h5
`define OP_STORE_INT  4'h6
`define OP_COMPARE    4'h7
`define OP_XTRACT     4'h8
`define OP_TANGENT    4'h9
`define OP_SCALE      4'hA
`define OP_TRANSC     4'hB
`define OP_ARITH      4'hC
`define OP_INIT       4'hD
`define OP_CLEAR_EXC  4'hE

// Operand classes
`define CL_ZERO       3'h0
`define CL_NORMAL     3'h1
`define CL_DENORM     3'h2
`define CL_INF        3'h3
`define CL_QNAN       3'h4
`define CL_SNAN       3'h5

// Load formats
`define FMT_EXT       2'h0

// Special result codes
`define RES_NONE      4'h0
`define RES_QNAN      4'h1
`define RES_POS_ZERO  4'h2
`define RES_NEG_ZERO  4'h3
`define RES_POS_INF   4'h4
`define RES_NEG_INF   4'h5
`define RES_POS_MAX   4'h6
`define RES_NEG_MAX   4'h7
`define RES_DENORM    4'h8

// Result register fields
`define RS_TOP_LSB    0
`define RS_TOP_MSB    3
`define RS_SEC_LSB    4
`define RS_SEC_MSB    7
`define RS_ROUNDED    8
`define RS_RC_LSB     9
`define RS_RC_MSB     10
`define RS_NORMED     11

`define ZERO32        32'h00000000
`define ZERO4         4'h0

`endif

// ==== verification/fpu_exc_checker_assertions.sv ====
// Port-level checker for the exception response block
`timescale 1ns/1ps
`default_nettype none
`include "fpu_exc_consts.vh"
module fpu_exc_checker
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata
);
  // ********************
  // Helpers and checks
  // ********************
  logic       st_rd_q;
  logic       cmd_seen_q;
  logic [5:0] flags_q;
  wire logic  acc    = psel && penable;
  wire logic  rd_set = psel && !penable && !pwrite;
  wire logic  mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
  wire logic  cmd_wr = acc && pwrite && paddr == `ADDR_CMD;
  wire logic  clr_wr = cmd_wr && (pwdata[3:0] == `OP_INIT ||
                                   pwdata[3:0] == `OP_CLEAR_EXC);

  // Last flag value read back, dropped when software clears the flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_rd_q    <= 1'b0;
      cmd_seen_q <= 1'b0;
      flags_q    <= 6'h00;
    end
    else
    begin
      st_rd_q    <= rd_set && paddr == `ADDR_STATUS;
      cmd_seen_q <= cmd_seen_q | cmd_wr;
      if (clr_wr)
        flags_q <= 6'h00;
      else if (st_rd_q)
        flags_q <= prdata[5:0];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_high_a:
    assert property (pready) else $error("pready low");
  unmapped_err_a:
    assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
  mapped_ok_a:
    assert property (acc && mapped |-> !pslverr) else $error("bad pslverr");
  err_idle_a:
    assert property (!acc |-> !pslverr) else $error("pslverr idle");
  rdata_hold_a:
    assert property (!rd_set |=> $stable(prdata)) else $error("prdata moved");
  unmapped_zero_a:
    assert property (rd_set && !mapped |=> prdata == 32'h0)
      else $error("unmapped data");
  cmd_rd_zero_a:
    assert property (rd_set && paddr == `ADDR_CMD |=> prdata == 32'h0)
      else $error("command reads back");
  reset_clear_a:
    assert property (st_rd_q && !cmd_seen_q |-> prdata[11:0] == 12'h000)
      else $error("status not clear");
  flags_sticky_a:
    assert property (st_rd_q |-> (prdata[5:0] & flags_q) == flags_q)
      else $error("flag lost");
  summary_bit_a:
    assert property (st_rd_q && prdata[7] |-> prdata[5:0] != 6'h00)
      else $error("summary without flag");

  cover property (cmd_wr);
  cover property (st_rd_q && prdata[5:0] != 6'h00);
  cover property (acc && !mapped);
endmodule

bind fpu_exception_response fpu_exc_checker i_fpu_exc_checker
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .prdata(prdata));
`default_nettype wire

// ==== verification/host_model.sv ====
// Host side: APB master issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock
  input  wire logic        pclk,
  // APB
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  // ********************
  // Transfer task
  // ********************
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // Call right after a rising edge; returns one edge after release
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the exception response block
`timescale 1ns/1ps
`default_nettype none
`include "fpu_exc_consts.vh"
module tb;
  // ********************
  // Bench
  // ********************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        e;
  int          n_errors;
  int          num_checks;
  localparam logic [31:0] M = 32'h3F;
  logic [7:0]  hp [4] = '{8'h04, 8'h06, 8'h04, 8'h06};
  logic [7:0]  hn [4] = '{8'h05, 8'h05, 8'h07, 8'h07};

  fpu_exception_response i_fpu_exception_response
    (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
     .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
     .pslverr(pslverr), .prdata(prdata));
  host_model i_host_model
    (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
     .paddr(paddr), .pwdata(pwdata), .pready(pready),
     .pslverr(pslverr), .prdata(prdata));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a);
    i_host_model.xfer(1'b0, a, 32'h0, r, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host_model.xfer(1'b1, a, d, r, e);
  endtask

  // Clear flags, launch one command, compare status and result codes
  task automatic run(input logic [31:0] c, input logic [31:0] cmd,
    input logic [11:0] st, input logic [7:0] res);
    wr(`ADDR_CTRL, c);
    wr(`ADDR_CMD, 32'h0E);
    wr(`ADDR_CMD, cmd);
    rd(`ADDR_STATUS);
    check({20'h0, r[11:0]}, {20'h0, st});
    rd(`ADDR_RESULT);
    if (res !== 8'hFF)
      check({24'h0, r[7:0]}, {24'h0, res});
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    n_errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ADDR_CTRL);
    check(r, M);
    rd(`ADDR_STATUS);
    check(r, 32'h0);
    rd(`ADDR_RESULT);
    check(r, 32'h0);
    wr(`ADDR_STATUS, 32'hFFF);
    rd(`ADDR_STATUS);
    check(r, 32'h0);
    rd(`ADDR_CMD);
    check(r, 32'h0);
    rd(12'h010);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    wr(12'h010, 32'h1);
    check({31'h0, e}, 32'h1);
    $display("test registers done");
    run(M, 32'h21, 12'h000, 8'hFF);
    run(M, 32'h1021, 12'h002, 8'hFF);
    run(M, 32'h2051, 12'h001, 8'h01);
    run(M, 32'h5C, 12'h001, 8'h01);
    run(M, 32'h4C, 12'h000, 8'h01);
    run(M, 32'h123, 12'h002, 8'hFF);
    run(M, 32'h26, 12'h002, 8'hFF);
    run(M, 32'h30022, 12'h032, 8'h08);
    run(M, 32'h10022, 12'h002, 8'h08);
    run(M, 32'h30015, 12'h030, 8'h08);
    run(M, 32'h30114, 12'h030, 8'h08);
    run(M, 32'h2B, 12'h002, 8'hFF);
    run(M, 32'h28, 12'h002, 8'hFF);
    run(M, 32'h08, 12'h004, 8'h50);
    run(M, 32'h25C, 12'h001, 8'h01);
    run(M, 32'h401C, 12'h041, 8'h01);
    run(M, 32'h4019, 12'h041, 8'h11);
    run(M, 32'h30A, 12'h001, 8'h01);
    run(M, 32'hB1A, 12'h000, 8'h02);
    run(M, 32'hB9A, 12'h000, 8'h03);
    run(M, 32'h31A, 12'h000, 8'h04);
    run(M, 32'h39A, 12'h000, 8'h05);
    run(32'h37, 32'hC009C, 12'h088, 8'h05);
    run(32'h2F, 32'h9001C, 12'h090, 8'h02);
    run(M, 32'h2C, 12'h002, 8'hFF);
    check({31'h0, r[11]}, 32'h1);
    run(32'h3D, 32'h2C, 12'h082, 8'hFF);
    check({31'h0, r[11]}, 32'h0);
    run(M, 32'h13, 12'h004, 8'h00);
    run(M, 32'h140993, 12'h028, 8'h04);
    run(M, 32'h130000, 12'h000, 8'h04);
    $display("test operations done");
    for (int i = 0; i < 4; i++)
    begin
      run(M | (i << 10), 32'h4001C, 12'h008, hp[i]);
      check({29'h0, r[10:8]}, {29'h0, i[1:0], 1'b1});
      run(M | (i << 10), 32'h4009C, 12'h008, hn[i]);
    end
    $display("test rounding done");
    run(M, 32'h47, 12'hD01, 8'h01);
    run(M, 32'h46, 12'hD01, 8'h01);
    run(M, 32'h45, 12'hD01, 8'h01);
    run(M, 32'h200114, 12'h000, 8'h00);
    $display("test nan done");
    wr(`ADDR_CMD, 32'h5C);
    wr(`ADDR_CMD, 32'h1021);
    rd(`ADDR_STATUS);
    check({26'h0, r[5:0]}, 32'h03);
    wr(`ADDR_CMD, 32'h0E);
    rd(`ADDR_STATUS);
    check({26'h0, r[5:0]}, 32'h00);
    run(32'hC3F, 32'h47, 12'hD01, 8'h01);
    wr(`ADDR_CMD, 32'h0D);
    rd(`ADDR_STATUS);
    check({20'h0, r[11:0]}, 32'h0);
    rd(`ADDR_CTRL);
    check(r, M);
    $display("test sticky done");
    report_and_stop();
  end
endmodule
`default_nettype wire
